// [hdl/lpmc_ctrl.sv]
// Purpose: Sleep/Idle entry and wake, CPU and peripheral gating, divided peripheral bus clock.
// Assumes: All inputs synchronous to sys_clk_i; the CPU holds wait_exec_i for one cycle.
// Notes: Clock sources are modelled by their enables; start-up delay counted in system cycles.
// Summary of operation
// - In Sleep an enabled interrupt from a source that runs in Sleep, with priority above the CPU priority, wakes the CPU.
// - In Sleep a lower or equal priority interrupt from a source that runs in Sleep restarts the bus clock and moves to Idle.
// - In Idle the CPU is halted while the system clock keeps running.
// - Peripherals with their stop-in-idle bit set halt in Idle; others keep running.
// - Wait with the sleep-select bit clear enters Idle.
// - In Idle only an interrupt with priority above the CPU priority or a watchdog time-out wakes the CPU.
// - The two-bit divider field sets a 1:1, 1:2, 1:4 or 1:8 bus clock for all bus peripherals.
// - Interrupt controller, DMA, USB, bus matrix and cache run on the undivided system clock.
// - A CPU peripheral read completes only at the next bus clock edge.
// - A previously disabled crystal or PLL source gets start-up and lock delay before use.
// - Leaving Idle on an already running source takes no start-up delay.
module lpmc_ctrl
	import lpmc_pkg::*;
(
	input wire logic sys_clk_i, // System clock, 10 MHz
	input wire logic rst_n_i, // Sync reset, active low
	input wire logic ce_i, // Clock enable, freezes all state
	input wire logic [lpmc_pkg::OSC_CTRL_W-1:0] osc_ctrl_i, // Oscillator control register image
	input wire logic wait_exec_i, // Wait instruction executed
	input wire logic irq_req_i, // Enabled interrupt pending
	input wire logic irq_in_sleep_i, // Pending source runs in Sleep
	input wire logic [lpmc_pkg::PRIO_W-1:0] irq_prio_i, // Pending interrupt priority
	input wire logic [lpmc_pkg::PRIO_W-1:0] cpu_prio_i, // Current CPU priority
	input wire logic wdt_timeout_i, // Watchdog time-out
	input wire logic src_xtal_pll_i, // Selected source uses crystal or PLL
	input wire logic src_pll_i, // Selected source uses the PLL
	input wire logic [lpmc_pkg::NUM_PERIPH-1:0] stop_in_idle_bit_i, // Per-peripheral stop-in-idle bits
	input wire logic pb_rd_req_i, // CPU peripheral read pending
	output logic cpu_run_o, // CPU clock enabled
	output logic sys_clk_en_o, // System clock source enabled
	output logic periph_bus_clock_o, // Peripheral bus clock enable pulse
	output logic [lpmc_pkg::NUM_PERIPH-1:0] periph_run_o, // Per-peripheral run enables
	output logic sys_periph_run_o, // Undivided-domain masters run
	output logic pb_rd_done_o, // Peripheral read completes
	output logic wake_o // One-cycle wake pulse
);
	lpmc_state_t state_ff, nxt_state;
	logic [START_CNT_W-1:0] start_cnt_ff, nxt_start_cnt;
	logic cpu_run_ff, nxt_cpu_run;
	logic sys_en_ff, nxt_sys_en;
	logic pb_run_ff, nxt_pb_run;
	logic wake_ff, nxt_wake;
	logic rd_done_ff, nxt_rd_done;
	logic [NUM_PERIPH-1:0] prun_ff, nxt_prun;
	logic sys_prun_ff, nxt_sys_periph_run;
	logic pb_en;
	logic sleep_sel;
	logic [1:0] div_sel;
	logic prio_win;

	assign sleep_sel = osc_ctrl_i[SLEEP_SEL_BIT];
	assign div_sel = osc_ctrl_i[PB_DIV_MSB:PB_DIV_LSB];
	assign prio_win = irq_req_i && (irq_prio_i > cpu_prio_i);

	// Divided bus clock; stops in Sleep and during start-up
	lpmc_pb_div u_pb_div (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.run_i(pb_run_ff),
		.div_sel_i(div_sel),
		.pb_en_o(pb_en)
	);

	// Power state machine
	always_comb begin
		logic [START_CNT_W-1:0] dly;
		dly = START_CNT_ZERO;
		if (src_xtal_pll_i) begin
			dly = START_CNT_W'(OSC_START_CYC);
			if (src_pll_i) begin
				dly = START_CNT_W'(OSC_START_CYC + PLL_LOCK_CYC);
			end
		end
		nxt_state = state_ff;
		nxt_start_cnt = start_cnt_ff;
		nxt_wake = 1'b0;
		case (state_ff)
			LPMC_RUN: begin
				if (wait_exec_i && !wdt_timeout_i) begin
					nxt_state = sleep_sel ? LPMC_SLEEP : LPMC_IDLE;
				end
			end
			LPMC_IDLE: begin
				if (prio_win || wdt_timeout_i) begin
					nxt_state = LPMC_RUN;
					nxt_wake = 1'b1;
				end
			end
			LPMC_SLEEP: begin
				if ((irq_req_i && irq_in_sleep_i) || wdt_timeout_i) begin
					nxt_start_cnt = dly;
					if (dly != START_CNT_ZERO) begin
						nxt_state = LPMC_START;
					end else if (prio_win || wdt_timeout_i) begin
						nxt_state = LPMC_RUN;
						nxt_wake = 1'b1;
					end else begin
						nxt_state = LPMC_IDLE;
					end
				end
			end
			LPMC_START: begin
				if (start_cnt_ff > START_CNT_ONE) begin
					nxt_start_cnt = start_cnt_ff - START_CNT_ONE;
				end else begin
					nxt_start_cnt = START_CNT_ZERO;
					// Source stable: decide like the Sleep exit
					if (prio_win || wdt_timeout_i) begin
						nxt_state = LPMC_RUN;
						nxt_wake = 1'b1;
					end else begin
						nxt_state = LPMC_IDLE;
					end
				end
			end
			default: nxt_state = LPMC_RUN;
		endcase
	end

	// Output enables from the next state, so outputs are registered
	always_comb begin
		nxt_cpu_run = (nxt_state == LPMC_RUN);
		nxt_sys_en = (nxt_state != LPMC_SLEEP) && (nxt_state != LPMC_START);
		nxt_pb_run = nxt_sys_en;
		nxt_sys_periph_run = nxt_sys_en;
		nxt_rd_done = pb_rd_req_i && pb_en && cpu_run_ff;
	end

	// Per-peripheral stop-in-idle gating
	for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_prun
		always_comb begin
			nxt_prun[g] = nxt_pb_run && !((nxt_state == LPMC_IDLE) && stop_in_idle_bit_i[g]);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= LPMC_RUN;
			start_cnt_ff <= START_CNT_ZERO;
			cpu_run_ff <= 1'b1;
			sys_en_ff <= 1'b1;
			pb_run_ff <= 1'b1;
			sys_prun_ff <= 1'b1;
			prun_ff <= '1;
			wake_ff <= 1'b0;
			rd_done_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			start_cnt_ff <= nxt_start_cnt;
			cpu_run_ff <= nxt_cpu_run;
			sys_en_ff <= nxt_sys_en;
			pb_run_ff <= nxt_pb_run;
			sys_prun_ff <= nxt_sys_periph_run;
			prun_ff <= nxt_prun;
			wake_ff <= nxt_wake;
			rd_done_ff <= nxt_rd_done;
		end
	end

	assign cpu_run_o = cpu_run_ff;
	assign sys_clk_en_o = sys_en_ff;
	assign periph_bus_clock_o = pb_en;
	assign periph_run_o = prun_ff;
	assign sys_periph_run_o = sys_prun_ff;
	assign pb_rd_done_o = rd_done_ff;
	assign wake_o = wake_ff;

	sequence s_in_run;
		state_ff == LPMC_RUN && ce_i && wait_exec_i && !wdt_timeout_i;
	endsequence

	idle_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_in_run ##0 !sleep_sel) |=> state_ff == LPMC_IDLE && !cpu_run_ff && sys_en_ff)
		else $error("wait with sleep-select clear did not enter idle");
	sleep_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(s_in_run ##0 sleep_sel) |=> state_ff == LPMC_SLEEP && !cpu_run_ff && !pb_run_ff)
		else $error("wait with sleep-select set did not stop cpu and bus clock");
	sleep_wake_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == LPMC_SLEEP && ce_i && irq_in_sleep_i && prio_win && !src_xtal_pll_i)
		|=> cpu_run_ff && wake_ff)
		else $error("high priority interrupt did not wake from sleep");
	sleep_to_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == LPMC_SLEEP && ce_i && irq_req_i && irq_in_sleep_i && !prio_win && !wdt_timeout_i
		&& !src_xtal_pll_i) |=> state_ff == LPMC_IDLE && !cpu_run_ff && pb_run_ff)
		else $error("low priority interrupt in sleep did not move to idle");
	idle_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == LPMC_IDLE && ce_i && !prio_win && !wdt_timeout_i) |=> state_ff == LPMC_IDLE)
		else $error("idle left without a qualifying wake");
	idle_clock_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == LPMC_IDLE) |-> sys_en_ff && !cpu_run_ff)
		else $error("idle must halt cpu with system clock on");
	wdt_wake_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == LPMC_IDLE && ce_i && wdt_timeout_i) |=> cpu_run_ff)
		else $error("watchdog time-out did not end idle");
	idle_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == LPMC_IDLE && $stable(stop_in_idle_bit_i)) |-> ((prun_ff & stop_in_idle_bit_i) == '0))
		else $error("stop-in-idle peripheral still running in idle");
	start_delay_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == LPMC_SLEEP && ce_i && ((irq_req_i && irq_in_sleep_i) || wdt_timeout_i) && src_xtal_pll_i)
		|=> (state_ff == LPMC_START && !cpu_run_ff) [*2])
		else $error("disabled crystal source used without start-up delay");
	read_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		rd_done_ff |-> $past(pb_en))
		else $error("peripheral read completed off a bus clock edge");
endmodule : lpmc_ctrl

// [shared/lpmc_pkg.sv]
// Purpose: Shared constants and types for the low-power mode and peripheral bus clock controller.
// Assumes: Single 10 MHz system clock, synchronous active-low reset.
// Notes: Field positions refer to the oscillator control register image presented on a port.
package lpmc_pkg;
	localparam int OSC_CTRL_W = 32;
	localparam int SLEEP_SEL_BIT = 4;
	localparam int PB_DIV_LSB = 19;
	localparam int PB_DIV_MSB = 20;
	localparam int PRIO_W = 3;
	localparam int NUM_PERIPH = 8;
	localparam int DIV_CNT_W = 3;
	localparam logic [1:0] PB_DIV_1 = 2'h0;
	localparam logic [1:0] PB_DIV_2 = 2'h1;
	localparam logic [1:0] PB_DIV_4 = 2'h2;
	localparam logic [1:0] PB_DIV_8 = 2'h3;
	localparam logic [DIV_CNT_W-1:0] DIV_MASK_1 = 3'h0;
	localparam logic [DIV_CNT_W-1:0] DIV_MASK_2 = 3'h1;
	localparam logic [DIV_CNT_W-1:0] DIV_MASK_4 = 3'h3;
	localparam logic [DIV_CNT_W-1:0] DIV_MASK_8 = 3'h7;
	localparam logic [DIV_CNT_W-1:0] DIV_CNT_RST = 3'h0;
	localparam logic [DIV_CNT_W-1:0] DIV_CNT_ONE = 3'h1;
	// Oscillator start-up and PLL lock times
	localparam int SYS_CLK_HZ = 10000000;
	localparam int OSC_START_US = 100;
	localparam int PLL_LOCK_US = 200;
	localparam int OSC_START_CYC = (OSC_START_US * (SYS_CLK_HZ / 1000000));
	localparam int PLL_LOCK_CYC = (PLL_LOCK_US * (SYS_CLK_HZ / 1000000));
	localparam int START_CNT_W = 12;
	localparam logic [START_CNT_W-1:0] START_CNT_ZERO = 12'h000;
	localparam logic [START_CNT_W-1:0] START_CNT_ONE = 12'h001;
	typedef enum logic [1:0] {LPMC_RUN, LPMC_IDLE, LPMC_SLEEP, LPMC_START} lpmc_state_t;
endpackage : lpmc_pkg

// [hdl/lpmc_pb_div.sv]
// Purpose: Glitch-free peripheral bus clock enable derived from the system clock.
// Assumes: Divider code taken as synchronous; run gates the enable.
// Notes: Counter re-phases only at a wrap so a divisor change never shortens a period.
module lpmc_pb_div
	import lpmc_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic rst_n_i, // Sync reset, active low
	input wire logic ce_i, // Clock enable
	input wire logic run_i, // Bus clock allowed to run
	input wire logic [1:0] div_sel_i, // Divider code
	output logic pb_en_o // Bus clock enable, one pulse per period
);
	logic [DIV_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [DIV_CNT_W-1:0] mask_ff, nxt_mask;
	logic pb_en_ff, nxt_pb_en;

	// Period mask from code; latched only at a wrap
	always_comb begin
		logic [DIV_CNT_W-1:0] m;
		m = DIV_MASK_1;
		case (div_sel_i)
			PB_DIV_1: m = DIV_MASK_1;
			PB_DIV_2: m = DIV_MASK_2;
			PB_DIV_4: m = DIV_MASK_4;
			PB_DIV_8: m = DIV_MASK_8;
			default: m = DIV_MASK_1;
		endcase
		nxt_cnt = cnt_ff;
		nxt_mask = mask_ff;
		nxt_pb_en = 1'b0;
		if (run_i) begin
			if (cnt_ff == mask_ff) begin
				nxt_cnt = DIV_CNT_RST;
				nxt_mask = m;
				nxt_pb_en = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + DIV_CNT_ONE;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cnt_ff <= DIV_CNT_RST;
			mask_ff <= DIV_MASK_1;
			pb_en_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			mask_ff <= nxt_mask;
			pb_en_ff <= nxt_pb_en;
		end
	end

	assign pb_en_o = pb_en_ff;

	pb_period_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(pb_en_ff && ce_i && run_i && mask_ff == DIV_MASK_2) |=> !pb_en_ff)
		else $error("bus enable repeated inside a 1:2 period");
endmodule : lpmc_pb_div

// [tb/lpmc_cpu_model.sv]
// Purpose: CPU-side model that issues peripheral reads and times their completion.
// Assumes: Launch request sampled on the rising edge.
// Notes: Holds the read until done is seen, as a stalled core would.
module lpmc_cpu_model
	import lpmc_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic rd_go_i, // Bench asks for one read
	input wire logic pb_rd_done_i, // Read complete from block
	output logic pb_rd_req_o, // Read request to block
	output int lat_o // Edges waited for last read
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		pb_rd_req_o = 1'b0;
		lat_o = 0;
	end
	// Request stays up until the completion pulse, never released early
	always @(posedge sys_clk_i) begin
		if (pb_rd_req_o && pb_rd_done_i) begin
			pb_rd_req_o <= 1'b0;
			lat_o <= lat_o + 1;
		end else if (pb_rd_req_o) begin
			lat_o <= lat_o + 1;
		end else if (rd_go_i) begin
			pb_rd_req_o <= 1'b1;
			lat_o <= 0;
		end
	end
endmodule : lpmc_cpu_model

// [tb/lpmc_ctrl_test.sv]
// Purpose: Self-checking bench for the low-power mode and bus clock controller.
// Assumes: Inputs change on the falling edge; ce_i drops only in the freeze step.
// Notes: Start-up waits use the package cycle counts, so a run takes a few thousand cycles.
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module lpmc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import lpmc_pkg::*;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, wait_exec_i = 1'b0, irq_req_i = 1'b0, irq_in_sleep_i = 1'b0;
	logic ce_i = 1'b1;
	logic wdt_timeout_i = 1'b0, src_xtal_pll_i = 1'b0, src_pll_i = 1'b0, rd_go = 1'b0;
	logic [OSC_CTRL_W-1:0] osc_ctrl_i = 32'h0;
	logic [PRIO_W-1:0] irq_prio_i = 3'h0, cpu_prio_i = 3'h0;
	logic [NUM_PERIPH-1:0] stop_in_idle_bit_i = 8'h00, periph_run_o;
	logic cpu_run_o, sys_clk_en_o, periph_bus_clock_o, sys_periph_run_o, pb_rd_done_o, wake_o, pb_rd_req;
	int lat, error_cnt = 0, checks = 0, cyc = 0;
	lpmc_ctrl lpmc_ctrl_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .osc_ctrl_i(osc_ctrl_i),
		.wait_exec_i(wait_exec_i), .irq_req_i(irq_req_i), .irq_in_sleep_i(irq_in_sleep_i),
		.irq_prio_i(irq_prio_i), .cpu_prio_i(cpu_prio_i), .wdt_timeout_i(wdt_timeout_i),
		.src_xtal_pll_i(src_xtal_pll_i), .src_pll_i(src_pll_i), .stop_in_idle_bit_i(stop_in_idle_bit_i),
		.pb_rd_req_i(pb_rd_req), .cpu_run_o(cpu_run_o), .sys_clk_en_o(sys_clk_en_o),
		.periph_bus_clock_o(periph_bus_clock_o), .periph_run_o(periph_run_o),
		.sys_periph_run_o(sys_periph_run_o), .pb_rd_done_o(pb_rd_done_o), .wake_o(wake_o));
	lpmc_cpu_model lpmc_cpu_model_i (.sys_clk_i(sys_clk_i), .rd_go_i(rd_go), .pb_rd_done_i(pb_rd_done_o),
		.pb_rd_req_o(pb_rd_req), .lat_o(lat));
	// 100 ns period clock and a hang guard well above the expected run
	always #50 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : tick
	task automatic do_wait(input logic slp);
		osc_ctrl_i[SLEEP_SEL_BIT] = slp;
		wait_exec_i = 1'b1;
		tick(1);
		wait_exec_i = 1'b0;
	endtask : do_wait
	task automatic set_irq(input logic req, input logic ins, input logic [2:0] pr);
		irq_req_i = req;
		irq_in_sleep_i = ins;
		irq_prio_i = pr;
		tick(1);
	endtask : set_irq
	// Counts bus clock pulses over a window, to show it stopped or runs
	task automatic pulses(input int n, output int k);
		k = 0;
		repeat (n) begin
			tick(1);
			if (periph_bus_clock_o === 1'b1) k++;
		end
	endtask : pulses
	task automatic t_reset;
		`CHK("cpu run", 1'b1, cpu_run_o)
		`CHK("periph run", 8'hFF, periph_run_o)
		`CHK("reset clk", 1'b1, sys_clk_en_o)
		$display("test reset done");
	endtask : t_reset
	// Reset in mid-run must end Sleep like any other wake source
	task automatic t_rst_sleep;
		do_wait(1'b1);
		`CHK("pre reset", 1'b0, cpu_run_o)
		rst_n_i = 1'b0;
		tick(8);
		rst_n_i = 1'b1;
		tick(1);
		`CHK("reset wake", 1'b1, cpu_run_o)
		`CHK("reset periph", 8'hFF, periph_run_o)
		$display("test reset in sleep done");
	endtask : t_rst_sleep
	task automatic t_div;
		int n;
		for (int c = 0; c < 4; c++) begin
			osc_ctrl_i[PB_DIV_MSB:PB_DIV_LSB] = c[1:0];
			tick(20);
			while (periph_bus_clock_o !== 1'b1) tick(1);
			n = 0;
			do begin
				tick(1);
				n++;
			end while (periph_bus_clock_o !== 1'b1);
			`CHK("bus period", 1 << c, n)
			`CHK("sys masters run", 1'b1, sys_periph_run_o)
		end
		$display("test divider done");
	endtask : t_div
	task automatic t_idle;
		stop_in_idle_bit_i = 8'hA5;
		cpu_prio_i = 3'h3;
		do_wait(1'b0);
		`CHK("idle cpu", 1'b0, cpu_run_o)
		`CHK("idle clk", 1'b1, sys_clk_en_o)
		`CHK("idle periph", 8'h5A, periph_run_o)
		set_irq(1'b1, 1'b0, 3'h3);
		tick(3);
		`CHK("equal prio", 1'b0, cpu_run_o)
		// Winning request while frozen must wait for the enable
		ce_i = 1'b0;
		set_irq(1'b1, 1'b0, 3'h4);
		tick(2);
		`CHK("frozen idle", 1'b0, cpu_run_o)
		ce_i = 1'b1;
		tick(1);
		`CHK("idle wake", 1'b1, cpu_run_o)
		`CHK("wake pulse", 1'b1, wake_o)
		set_irq(1'b0, 1'b0, 3'h0);
		`CHK("wake end", 1'b0, wake_o)
		$display("test idle done");
	endtask : t_idle
	task automatic t_sleep;
		int k;
		cpu_prio_i = 3'h2;
		do_wait(1'b1);
		`CHK("sleep clk", 1'b0, sys_clk_en_o)
		`CHK("sleep periph", 8'h00, periph_run_o)
		`CHK("sleep masters", 1'b0, sys_periph_run_o)
		set_irq(1'b1, 1'b0, 3'h6);
		pulses(9, k);
		`CHK("sleep pulses", 0, k)
		`CHK("non sleep src", 1'b0, cpu_run_o)
		set_irq(1'b1, 1'b1, 3'h2);
		`CHK("to idle clk", 1'b1, sys_clk_en_o)
		pulses(9, k);
		`CHK("idle pulses", 1'b1, k > 0)
		`CHK("to idle cpu", 1'b0, cpu_run_o)
		set_irq(1'b0, 1'b0, 3'h0);
		wdt_timeout_i = 1'b1;
		tick(1);
		wdt_timeout_i = 1'b0;
		`CHK("wdt wake", 1'b1, cpu_run_o)
		do_wait(1'b1);
		set_irq(1'b1, 1'b1, 3'h3);
		`CHK("sleep wake", 1'b1, cpu_run_o)
		set_irq(1'b0, 1'b0, 3'h0);
		$display("test sleep done");
	endtask : t_sleep
	task automatic t_start;
		int k, exp;
		for (int p = 0; p < 2; p++) begin
			exp = OSC_START_CYC + ((p == 1) ? PLL_LOCK_CYC : 0);
			src_xtal_pll_i = 1'b1;
			src_pll_i = p[0];
			do_wait(1'b1);
			set_irq(1'b1, 1'b1, 3'h5);
			tick(exp - 20);
			`CHK("still starting", 1'b0, cpu_run_o)
			k = 0;
			while (cpu_run_o !== 1'b1 && k < 100) begin
				tick(1);
				k++;
			end
			`CHK("start done", 1'b1, k > 0 && k < 60)
			set_irq(1'b0, 1'b0, 3'h0);
			src_xtal_pll_i = 1'b0;
		end
		$display("test start-up done");
	endtask : t_start
	task automatic t_read;
		for (int i = 0; i < 6; i++) begin
			osc_ctrl_i[PB_DIV_MSB:PB_DIV_LSB] = (i < 3) ? 2'h0 : 2'h3;
			// A new code takes hold only at a wrap, up to eight cycles away
			tick(8 + i);
			rd_go = 1'b1;
			tick(1);
			rd_go = 1'b0;
			repeat (20) if (pb_rd_req === 1'b1) tick(1);
			`CHK("read latency", 1'b1, lat >= 2 && lat <= ((i < 3) ? 2 : 9))
		end
		$display("test read done");
	endtask : t_read
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test
	initial begin
		tick(16);
		rst_n_i = 1'b1;
		tick(1);
		t_reset();
		t_div();
		t_idle();
		t_sleep();
		t_rst_sleep();
		t_start();
		t_read();
		finish_test();
	end
endmodule : lpmc_ctrl_test
